// *** verilog/volpin_pkg.sv ***
// Constants and types for the volume pins and pin function select block.
// Assumes a single 40 MHz clock and active-low asynchronous reset rst_b.
// What this block does
// [RULE1] By default the shared acknowledge pin forwards the drive DMA acknowledge.
// [RULE2] The acknowledge pin becomes the active-low modem select once the modem base goes non-zero.
// [RULE3] Volume pins act only while the volume-control enable bit is set.
// [RULE4] The two format bits choose only the mute switch style; the volume up and down pins behave alike in every format.
// [RULE5] The synth select pin turns into the volume-up input while volume control is enabled.
// [RULE6] A low volume-up input raises both left and right master volume.
// [RULE7] The four-function pin turns into the volume-down input while volume control is enabled.
// [RULE8] A low volume-down input lowers both left and right master volume.
// [RULE9] Mute works only when enabled and is toggle, momentary or absent per the format bits.
// [RULE10] While the reset input is high the block, apart from the strap latches and interrupt level, is held reset and powered down.
// [RULE11] On the reset input falling edge both external strobe levels are latched to fix pin roles.
// [RULE12] While the reset input is high the wavetable reset output is driven low.
// [RULE13] The system asserts the reset input at every power-up.
// [RULE14] The sampled read strobe level decides if the drive port replaces the upper address inputs.
// [RULE15] Volume-control enable beats every other role of the pins it touches.
// [RULE16] The four-function pin becomes the alternate drive select once its base goes non-zero.
// [RULE17] Volume inputs are synchronised, debounced, repeat while held and saturate at the ends.
package volpin_pkg;
	localparam int VOL_W = 6;
	localparam logic [5:0] VOL_MAX = 6'h3F;
	localparam logic [5:0] VOL_MIN = 6'h00;
	localparam logic [5:0] VOL_RESET = 6'h20;
	localparam int BASE_W = 12;
	localparam int CLK_MHZ = 40;
	localparam int DEBOUNCE_US = 10000;
	localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
	localparam int REPEAT_US = 100000;
	localparam int REPEAT_CYC = REPEAT_US * CLK_MHZ;
	localparam int CNT_W = 23;
	// Format field encodings
	localparam logic [1:0] FMT_TOGGLE = 2'h0;
	localparam logic [1:0] FMT_MOMENTARY = 2'h1;
	localparam logic [1:0] FMT_NO_MUTE = 2'h2;
	localparam logic [1:0] FMT_NO_MUTE_ALT = 2'h3;
	typedef enum logic [1:0] {
		FN_CONTROL_OUT,
		FN_SYNTH_IRQ,
		FN_ALT_SELECT,
		FN_VOL_DOWN
	} pin4_fn_type;
endpackage : volpin_pkg

// *** verilog/vol_button_if.sv ***
// Button carrier between the top module and the debounce module.
// Assumes both ends run on clk.
`timescale 1ns/1ps
interface vol_button_if;
	logic raw_n;
	logic pressed;
	logic step;
	modport filt (input raw_n, output pressed, output step);
	modport user (output raw_n, input pressed, input step);
endinterface : vol_button_if

// *** verilog/vol_button.sv ***
// Synchroniser, debounce and auto-repeat for one active-low switch.
// Assumes the raw input is asynchronous to clk.
`timescale 1ns/1ps
module vol_button #(
	parameter int DEB_CYC = volpin_pkg::DEBOUNCE_CYC,
	parameter int REP_CYC = volpin_pkg::REPEAT_CYC
) (
	input wire clk,
	input wire rst_b,
	input wire hold,
	vol_button_if.filt btn
);
	import volpin_pkg::*;
	logic [2:0] sync_q;
	logic stable_q;
	logic [CNT_W-1:0] deb_q;
	logic [CNT_W-1:0] rep_q;
	logic step_q;
	logic agree;
	assign agree = (sync_q[1] == sync_q[2]);
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sync_q <= 3'h7;
		end else begin
			sync_q <= {sync_q[1:0], btn.raw_n};
		end
	end
	// Level must stay put for the whole debounce window before it counts
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stable_q <= 1'b1;
			deb_q <= '0;
		end else if (hold) begin
			stable_q <= 1'b1;
			deb_q <= '0;
		end else if (!agree || sync_q[2] == stable_q) begin
			deb_q <= '0;
		end else if (deb_q == CNT_W'(DEB_CYC - 1)) begin // RULE17
			stable_q <= sync_q[2];
			deb_q <= '0;
		end else begin
			deb_q <= deb_q + 1'b1;
		end
	end
	// First step on the press, then one per repeat period while held
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rep_q <= '0;
			step_q <= 1'b0;
		end else if (stable_q || hold) begin
			rep_q <= '0;
			step_q <= 1'b0;
		end else begin
			step_q <= (rep_q == '0);
			rep_q <= (rep_q == CNT_W'(REP_CYC - 1)) ? '0 : rep_q + 1'b1; // RULE17
		end
	end
	assign btn.pressed = ~stable_q;
	assign btn.step = step_q;
	a_step_single: assert property (@(posedge clk) disable iff (!rst_b) // RULE17
		step_q |=> !step_q) else $error("step lasted more than one cycle");
endmodule : vol_button

// *** verilog/volume_pins.sv ***
// Volume push-button pins, mute and shared pin function selection.
// Assumes configuration bits and base addresses come from elsewhere as levels on clk.
`timescale 1ns/1ps
module volume_pins #(
	parameter int DEB_CYC = volpin_pkg::DEBOUNCE_CYC,
	parameter int REP_CYC = volpin_pkg::REPEAT_CYC
) (
	input wire clk,
	input wire rst_b,
	input wire reset_powerdown_in,
	input wire ext_read_strobe_n,
	input wire ext_write_strobe_n,
	input wire vol_ctrl_enable,
	input wire [1:0] vol_format_bits,
	input wire [volpin_pkg::BASE_W-1:0] modem_base_addr,
	input wire [volpin_pkg::BASE_W-1:0] alt_drive_base_addr,
	input wire bus_dma_ack_n,
	input wire synth_decode_n,
	input wire general_control_out1,
	input wire alt_decode_n,
	input wire pin4_in,
	input wire synth_pin_in,
	input wire mute_in_n,
	output logic drive_dma_ack_out,
	output logic modem_select_n,
	output logic ack_pin_out,
	output logic synth_pin_out,
	output logic synth_pin_oe,
	output logic pin4_out,
	output logic pin4_oe,
	output logic synth_irq_in,
	output volpin_pkg::pin4_fn_type pin4_fn,
	output logic drive_port_enable,
	output logic strap_write_q,
	output logic powerdown,
	output logic wavetable_reset_out_n,
	output logic [volpin_pkg::VOL_W-1:0] vol_left,
	output logic [volpin_pkg::VOL_W-1:0] vol_right,
	output logic mute
);
	import volpin_pkg::*;

	logic [2:0] rdrv_sync_q;
	logic [2:0] rd_sync_q;
	logic [2:0] wr_sync_q;
	logic [2:0] irq_sync_q;
	logic [2:0] mute_sync_q;
	logic rdrv_q;
	logic hold;
	logic rdrv_fall;
	logic modem_sel_q;
	logic alt_sel_q;
	logic strap_read_q;
	logic irq_q;
	logic [VOL_W-1:0] vol_q;
	logic mute_q;
	logic mute_prev_q;
	logic vc_on;
	logic up_en;
	logic dn_en;

	// Second and third stages agree, so the pin level is trusted
	function automatic logic settled(input logic [2:0] s);
		return s[1] == s[2];
	endfunction : settled

	vol_button_if up_if ();
	vol_button_if dn_if ();

	// Three-stage synchronisers; reset, interrupt and mute wait until second and third agree
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdrv_sync_q <= 3'h7;
			rd_sync_q <= 3'h7;
			wr_sync_q <= 3'h7;
			irq_sync_q <= 3'h7;
			mute_sync_q <= 3'h7;
		end else begin
			rdrv_sync_q <= {rdrv_sync_q[1:0], reset_powerdown_in};
			rd_sync_q <= {rd_sync_q[1:0], ext_read_strobe_n};
			wr_sync_q <= {wr_sync_q[1:0], ext_write_strobe_n};
			irq_sync_q <= {irq_sync_q[1:0], pin4_in};
			mute_sync_q <= {mute_sync_q[1:0], mute_in_n};
		end
	end

	// Reset starts asserted; only a clean low releases it
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdrv_q <= 1'b1;
		end else if (settled(rdrv_sync_q)) begin
			rdrv_q <= rdrv_sync_q[2];
		end
	end
	assign hold = rdrv_q;
	assign rdrv_fall = rdrv_q && settled(rdrv_sync_q) && !rdrv_sync_q[2];
	assign powerdown = hold; // RULE10
	assign wavetable_reset_out_n = ~hold; // RULE12

	// Straps caught at the falling edge, default high
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			strap_read_q <= 1'b1;
			strap_write_q <= 1'b1;
		end else if (rdrv_fall) begin
			strap_read_q <= rd_sync_q[2]; // RULE11
			strap_write_q <= wr_sync_q[2]; // RULE11
		end
	end
	// Pulled low at reset enables the drive port
	assign drive_port_enable = ~strap_read_q; // RULE14

	// Switch-over happens once and sticks until reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			modem_sel_q <= 1'b0;
			alt_sel_q <= 1'b0;
		end else if (hold) begin
			modem_sel_q <= 1'b0;
			alt_sel_q <= 1'b0;
		end else begin
			if (modem_base_addr != '0) begin
				modem_sel_q <= 1'b1; // RULE2
			end
			if (alt_drive_base_addr != '0) begin
				alt_sel_q <= 1'b1; // RULE16
			end
		end
	end

	always_comb begin
		drive_dma_ack_out = bus_dma_ack_n;
		modem_select_n = 1'b1;
		ack_pin_out = bus_dma_ack_n; // RULE1
		if (modem_sel_q) begin
			modem_select_n = synth_decode_n & alt_decode_n;
			ack_pin_out = modem_select_n; // RULE2
			drive_dma_ack_out = 1'b1;
		end
	end

	assign vc_on = vol_ctrl_enable && !hold; // RULE3

	// Enable wins over every other role
	always_comb begin
		if (vc_on) begin
			pin4_fn = FN_VOL_DOWN; // RULE7 RULE15
		end else if (alt_sel_q) begin
			pin4_fn = FN_ALT_SELECT; // RULE16
		end else if (!strap_write_q) begin
			pin4_fn = FN_SYNTH_IRQ;
		end else begin
			pin4_fn = FN_CONTROL_OUT;
		end
	end

	always_comb begin
		pin4_oe = 1'b0;
		pin4_out = 1'b1;
		case (pin4_fn)
			FN_CONTROL_OUT: begin
				pin4_oe = 1'b1;
				pin4_out = general_control_out1;
			end
			FN_ALT_SELECT: begin
				pin4_oe = 1'b1;
				pin4_out = alt_decode_n;
			end
			default: begin
				pin4_oe = 1'b0;
				pin4_out = 1'b1;
			end
		endcase
	end

	// Interrupt level only moves once the pin has settled
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_q <= 1'b0;
		end else if (settled(irq_sync_q)) begin
			irq_q <= ~irq_sync_q[2];
		end
	end
	assign synth_irq_in = (pin4_fn == FN_SYNTH_IRQ) ? irq_q : 1'b0;
	assign synth_pin_oe = ~vc_on; // RULE5 RULE15
	assign synth_pin_out = synth_decode_n;

	// Buttons only see their pin in volume mode
	assign up_if.raw_n = vc_on ? synth_pin_in : 1'b1; // RULE5
	assign dn_if.raw_n = vc_on ? pin4_in : 1'b1; // RULE7
	assign up_en = vc_on && up_if.step;
	assign dn_en = vc_on && dn_if.step;

	vol_button #(.DEB_CYC(DEB_CYC), .REP_CYC(REP_CYC)) u_up (
		.clk(clk),
		.rst_b(rst_b),
		.hold(!vc_on),
		.btn(up_if)
	);
	vol_button #(.DEB_CYC(DEB_CYC), .REP_CYC(REP_CYC)) u_dn (
		.clk(clk),
		.rst_b(rst_b),
		.hold(!vc_on),
		.btn(dn_if)
	);

	// Both pressed cancels out rather than favouring one
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			vol_q <= VOL_RESET;
		end else if (hold) begin
			vol_q <= VOL_RESET;
		end else if (up_en && !dn_en && vol_q != VOL_MAX) begin
			vol_q <= vol_q + 1'b1; // RULE6 RULE17
		end else if (dn_en && !up_en && vol_q != VOL_MIN) begin
			vol_q <= vol_q - 1'b1; // RULE8 RULE17
		end
	end
	assign vol_left = vol_q;
	assign vol_right = vol_q;

	// Mute is unfiltered: a toggle switch bounce only matters for edges
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mute_q <= 1'b0;
			mute_prev_q <= 1'b1;
		end else if (!vc_on) begin
			mute_q <= 1'b0; // RULE9
			mute_prev_q <= 1'b1;
		end else if (settled(mute_sync_q)) begin
			mute_prev_q <= mute_sync_q[2];
			case (vol_format_bits) // RULE4
				FMT_TOGGLE: begin
					if (mute_prev_q && !mute_sync_q[2]) begin
						mute_q <= ~mute_q; // RULE9
					end
				end
				FMT_MOMENTARY: begin
					mute_q <= ~mute_sync_q[2]; // RULE9
				end
				default: begin
					mute_q <= 1'b0; // RULE9
				end
			endcase
		end
	end
	assign mute = mute_q;

	// Volume stepping and its limits
	a_vol_up_step: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
		up_en && !dn_en && !hold && vol_q != VOL_MAX |=> vol_q == $past(vol_q) + 1'b1)
		else $error("volume did not step up");
	a_vol_down_step: assert property (@(posedge clk) disable iff (!rst_b) // RULE8
		dn_en && !up_en && !hold && vol_q != VOL_MIN |=> vol_q == $past(vol_q) - 1'b1)
		else $error("volume did not step down");
	a_vol_top_sat: assert property (@(posedge clk) disable iff (!rst_b) // RULE17
		up_en && !dn_en && vol_q == VOL_MAX |=> vol_q == VOL_MAX)
		else $error("volume wrapped past the top");
	a_vol_idle_off: assert property (@(posedge clk) disable iff (!rst_b) // RULE3
		!vc_on && !hold |=> $stable(vol_q)) else $error("volume moved while disabled");
	a_vol_reset_hold: assert property (@(posedge clk) disable iff (!rst_b) // RULE10
		hold |=> vol_q == VOL_RESET && !mute_q) else $error("held reset left state");

	// Pin roles, reset input and straps
	a_pin4_priority: assert property (@(posedge clk) disable iff (!rst_b) // RULE15
		vc_on |-> pin4_fn == FN_VOL_DOWN && !pin4_oe && !synth_pin_oe)
		else $error("volume enable lost priority");
	a_irq_no_drive: assert property (@(posedge clk) disable iff (!rst_b) // RULE11
		pin4_fn == FN_SYNTH_IRQ |-> !pin4_oe) else $error("interrupt pin driven");
	a_wt_reset_low: assert property (@(posedge clk) disable iff (!rst_b) // RULE12
		rdrv_sync_q[2] && rdrv_sync_q[1] |=> !wavetable_reset_out_n && powerdown)
		else $error("held reset not shown");
	a_hold_release: assert property (@(posedge clk) disable iff (!rst_b) // RULE10
		!rdrv_sync_q[2] && !rdrv_sync_q[1] |=> !powerdown && wavetable_reset_out_n)
		else $error("released reset not shown");
	a_strap_latch: assert property (@(posedge clk) disable iff (!rst_b) // RULE11
		rdrv_fall |=> strap_read_q == $past(rd_sync_q[2]) && strap_write_q == $past(wr_sync_q[2]))
		else $error("strap not latched");
	a_strap_hold: assert property (@(posedge clk) disable iff (!rst_b) // RULE11
		!rdrv_fall |=> $stable(strap_read_q) && $stable(strap_write_q))
		else $error("strap moved outside the reset fall");
	a_irq_sync: assert property (@(posedge clk) disable iff (!rst_b) // RULE11
		irq_sync_q[1] == irq_sync_q[2] |=> irq_q == ~$past(irq_sync_q[2]))
		else $error("interrupt level not settled");
	a_modem_sticky: assert property (@(posedge clk) disable iff (!rst_b) // RULE2
		modem_sel_q && !hold |=> modem_sel_q) else $error("modem select dropped");
	a_modem_take: assert property (@(posedge clk) disable iff (!rst_b) // RULE2
		modem_base_addr != '0 && !hold |=> modem_sel_q) else $error("modem select not taken");
	a_alt_take: assert property (@(posedge clk) disable iff (!rst_b) // RULE16
		alt_drive_base_addr != '0 && !hold |=> alt_sel_q) else $error("alt select not taken");
	a_ack_default: assert property (@(posedge clk) disable iff (!rst_b) // RULE1
		!modem_sel_q |-> ack_pin_out == bus_dma_ack_n) else $error("ack not forwarded");
	a_ack_hold: assert property (@(posedge clk) disable iff (!rst_b) // RULE1
		hold |=> ack_pin_out == bus_dma_ack_n) else $error("ack not restored by reset");

	// Mute formats
	a_mute_moment: assert property (@(posedge clk) disable iff (!rst_b) // RULE9
		vol_format_bits == FMT_MOMENTARY && vc_on && mute_sync_q[1] == mute_sync_q[2]
		|=> mute_q == ~$past(mute_sync_q[2])) else $error("momentary mute not followed");
	a_mute_absent: assert property (@(posedge clk) disable iff (!rst_b) // RULE9
		vol_format_bits[1] && vc_on ##1 vol_format_bits[1] && vc_on && mute_sync_q[1] == mute_sync_q[2]
		|=> !mute_q) else $error("mute active in absent format");

	// Main scenarios
	c_vol_up: cover property (@(posedge clk) disable iff (!rst_b) up_en && vol_q == VOL_MAX - 1'b1);
	c_vol_down: cover property (@(posedge clk) disable iff (!rst_b) dn_en);
	c_vol_held_top: cover property (@(posedge clk) disable iff (!rst_b)
		up_if.pressed && !dn_if.pressed && vol_q == VOL_MAX);
	c_mute_toggle: cover property (@(posedge clk) disable iff (!rst_b) $rose(mute_q));
	c_modem_switch: cover property (@(posedge clk) disable iff (!rst_b) $rose(modem_sel_q));
endmodule : volume_pins

// *** dv/vol_panel_model.sv ***
// Front-panel volume switches and bus reset source facing the volume pin block.
// Assumes the bench sets the press and reset requests at the falling clock edge.
`timescale 1ns/1ps
module vol_panel_model (
	input wire logic up_req,
	input wire logic down_req,
	input wire logic mute_req,
	input wire logic bus_reset_req,
	input wire logic synth_pin_out,
	input wire logic synth_pin_oe,
	input wire logic pin4_out,
	input wire logic pin4_oe,
	output logic synth_pin_in,
	output logic pin4_in,
	output logic mute_in_n,
	output logic reset_powerdown_in
);
	// Pull-ups hold released switches high; a pin the block drives wins
	assign synth_pin_in = synth_pin_oe ? synth_pin_out : !up_req;
	assign pin4_in = pin4_oe ? pin4_out : !down_req;
	assign mute_in_n = !mute_req;
	assign reset_powerdown_in = bus_reset_req;
endmodule : vol_panel_model

// *** dv/volume_pins_tb.sv ***
// Self-checking bench for the volume pin and pin function select block.
// Assumes short debounce and repeat counts; inputs change on the falling edge.
`timescale 1ns/1ps
module volume_pins_tb;
	import volpin_pkg::*;
	logic clk = 1'h0;
	logic rst_b = 1'h0;
	logic ext_read_strobe_n = 1'h1;
	logic ext_write_strobe_n = 1'h1;
	logic vol_ctrl_enable = 1'h0;
	logic [1:0] vol_format_bits = 2'h0;
	logic [BASE_W-1:0] modem_base_addr = 12'h000;
	logic [BASE_W-1:0] alt_drive_base_addr = 12'h000;
	logic bus_dma_ack_n = 1'h1;
	logic synth_decode_n = 1'h1;
	logic alt_decode_n = 1'h1;
	logic general_control_out1 = 1'h1;
	logic up_req = 1'h0;
	logic down_req = 1'h0;
	logic mute_req = 1'h0;
	logic bus_reset_req = 1'h1;
	logic reset_powerdown_in, synth_pin_in, pin4_in, mute_in_n;
	logic drive_dma_ack_out, modem_select_n, ack_pin_out, synth_pin_out, synth_pin_oe;
	logic pin4_out, pin4_oe, synth_irq_in, drive_port_enable, strap_write_q;
	logic powerdown, wavetable_reset_out_n, mute;
	logic [VOL_W-1:0] vol_left, vol_right;
	pin4_fn_type pin4_fn;
	int n_errors = 0;
	int checked = 0;

	volume_pins #(.DEB_CYC(4), .REP_CYC(16)) i_dut (.clk, .rst_b, .reset_powerdown_in,
		.ext_read_strobe_n, .ext_write_strobe_n, .vol_ctrl_enable, .vol_format_bits,
		.modem_base_addr, .alt_drive_base_addr, .bus_dma_ack_n, .synth_decode_n,
		.general_control_out1, .alt_decode_n, .pin4_in, .synth_pin_in, .mute_in_n,
		.drive_dma_ack_out, .modem_select_n, .ack_pin_out, .synth_pin_out, .synth_pin_oe,
		.pin4_out, .pin4_oe, .synth_irq_in, .pin4_fn, .drive_port_enable, .strap_write_q,
		.powerdown, .wavetable_reset_out_n, .vol_left, .vol_right, .mute);
	vol_panel_model i_panel (.up_req, .down_req, .mute_req, .bus_reset_req, .synth_pin_out,
		.synth_pin_oe, .pin4_out, .pin4_oe, .synth_pin_in, .pin4_in, .mute_in_n,
		.reset_powerdown_in);

	initial begin
		forever #12.5 clk = ~clk;
	end

	task automatic report_and_stop();
		$display("checked=%0d n_errors=%0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_bit

	task automatic chk_val(input logic [5:0] got, input logic [5:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_val

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	// Bounded wait; a stuck volume ends the run rather than hanging it
	task automatic wait_vol(input logic [5:0] exp);
		int i;
		for (i = 0; i < 600; i++) begin
			if (vol_left === exp) break;
			@(negedge clk);
		end
		if (i == 600) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, vol_left, exp);
			report_and_stop();
		end
		chk_val(vol_left, exp);
		chk_val(vol_right, exp);
	endtask : wait_vol

	task automatic t_power();
		cyc(3);
		chk_bit(powerdown, 1'h1);
		chk_bit(wavetable_reset_out_n, 1'h0);
		chk_val(vol_left, VOL_RESET);
		$display("test power done");
	endtask : t_power

	task automatic t_straps();
		ext_read_strobe_n = 1'h0;
		cyc(2);
		bus_reset_req = 1'h0;
		cyc(6);
		ext_read_strobe_n = 1'h1;
		ext_write_strobe_n = 1'h0;
		cyc(2);
		chk_bit(drive_port_enable, 1'h1);
		chk_bit(strap_write_q, 1'h1);
		chk_bit(powerdown, 1'h0);
		chk_bit(wavetable_reset_out_n, 1'h1);
		$display("test straps done");
	endtask : t_straps

	task automatic t_pins();
		for (int i = 0; i < 2; i++) begin
			bus_dma_ack_n = i[0];
			cyc(1);
			chk_bit(drive_dma_ack_out, i[0]);
			chk_bit(ack_pin_out, i[0]);
		end
		chk_bit(modem_select_n, 1'h1);
		chk_val(pin4_fn, FN_CONTROL_OUT);
		chk_bit(pin4_out, 1'h1);
		chk_bit(synth_pin_oe, 1'h1);
		general_control_out1 = 1'h0;
		synth_decode_n = 1'h0;
		cyc(1);
		chk_bit(pin4_out, 1'h0);
		chk_bit(pin4_oe, 1'h1);
		chk_bit(synth_pin_out, 1'h0);
		general_control_out1 = 1'h1;
		synth_decode_n = 1'h1;
		up_req = 1'h1;
		down_req = 1'h1;
		cyc(40);
		chk_val(vol_left, VOL_RESET);
		up_req = 1'h0;
		down_req = 1'h0;
		$display("test pins done");
	endtask : t_pins

	task automatic t_volume();
		vol_ctrl_enable = 1'h1;
		alt_drive_base_addr = 12'h170;
		cyc(2);
		chk_bit(synth_pin_oe, 1'h0);
		chk_bit(pin4_oe, 1'h0);
		chk_val(pin4_fn, FN_VOL_DOWN);
		up_req = 1'h1;
		wait_vol(6'h21);
		wait_vol(VOL_MAX);
		cyc(40);
		chk_val(vol_left, VOL_MAX);
		up_req = 1'h0;
		down_req = 1'h1;
		wait_vol(6'h3E);
		down_req = 1'h0;
		cyc(4);
		$display("test volume done");
	endtask : t_volume

	task automatic t_mute();
		logic [1:0] fm [6] = '{FMT_TOGGLE, FMT_TOGGLE, FMT_MOMENTARY, FMT_NO_MUTE,
			FMT_NO_MUTE_ALT, FMT_MOMENTARY};
		logic [5:0] pe = 6'h05;
		logic [5:0] re = 6'h01;
		for (int i = 0; i < 6; i++) begin
			vol_format_bits = fm[i];
			vol_ctrl_enable = 1'(i != 5);
			mute_req = 1'h1;
			cyc(8);
			chk_bit(mute, pe[i]);
			mute_req = 1'h0;
			cyc(8);
			chk_bit(mute, re[i]);
		end
		$display("test mute done");
	endtask : t_mute

	task automatic t_switch();
		cyc(2);
		chk_val(pin4_fn, FN_ALT_SELECT);
		alt_decode_n = 1'h0;
		cyc(1);
		chk_bit(pin4_out, 1'h0);
		alt_decode_n = 1'h1;
		modem_base_addr = 12'h2F8;
		bus_dma_ack_n = 1'h0;
		cyc(2);
		chk_bit(drive_dma_ack_out, 1'h1);
		modem_base_addr = 12'h000;
		synth_decode_n = 1'h0;
		cyc(2);
		chk_bit(modem_select_n, 1'h0);
		chk_bit(ack_pin_out, 1'h0);
		synth_decode_n = 1'h1;
		$display("test switch done");
	endtask : t_switch

	task automatic t_reset();
		alt_drive_base_addr = 12'h000;
		bus_reset_req = 1'h1;
		ext_read_strobe_n = 1'h1;
		ext_write_strobe_n = 1'h0;
		cyc(5);
		chk_bit(powerdown, 1'h1);
		chk_bit(wavetable_reset_out_n, 1'h0);
		chk_val(vol_left, VOL_RESET);
		chk_bit(drive_dma_ack_out, 1'h0);
		bus_reset_req = 1'h0;
		cyc(6);
		chk_bit(drive_port_enable, 1'h0);
		chk_bit(strap_write_q, 1'h0);
		chk_val(pin4_fn, FN_SYNTH_IRQ);
		down_req = 1'h1;
		cyc(5);
		chk_bit(synth_irq_in, 1'h1);
		down_req = 1'h0;
		cyc(5);
		chk_bit(synth_irq_in, 1'h0);
		$display("test reset done");
	endtask : t_reset

	initial begin
		cyc(10);
		rst_b = 1'h1;
		t_power();
		t_straps();
		t_pins();
		t_volume();
		t_mute();
		t_switch();
		t_reset();
		report_and_stop();
	end
endmodule : volume_pins_tb
